// >>> hdl/data_memory_access_unit.sv
// Purpose: Routes core data moves to on-chip SRAM or the external bus, stretches
//   external strobes, shows lock status, and holds two selectable data pointers.
// Assumes: pclk at 50 MHz, four clocks per machine cycle, one request at a time.
// Notes: Pin outputs are registered, so the pin waveform trails the counter by one clock.
// How it works
// RULE1: Two mapping bits in power_management select data mapping; writable anytime.
// RULE2: Mapping 00, the reset state, sends every data move to the external bus.
// RULE3: Mapping 01 puts 0000h-03FFh in SRAM and the rest on the external bus.
// RULE4: Mapping 11 adds lock status at FFFCh; other high addresses make no bus access.
// RULE5: Lock status bits 2-0 read 1 for each programmed security lock.
// RULE6: Changing mapping bits never alters SRAM contents.
// RULE7: Internal SRAM moves always take two machine cycles.
// RULE8: Stretch from clock_control bits 2-0; external move lasts stretch plus two cycles.
// RULE9: Stretch resets to 1, giving three-cycle external moves.
// RULE10: Strobe is 2 clocks at stretch 0, else four clocks times stretch.
// RULE11: Nonzero stretch adds one clock of setup and one of hold.
// RULE12: Stretch affects data moves only, never program fetch timing.
// RULE13: Two 16-bit pointers, bytes at 82h/83h and 84h/85h.
// RULE14: Bit 0 of 86h selects the pointer; other bits ignored and read zero.
// RULE15: Pointer loads, increments and data moves use the selected pointer.
// RULE16: External moves drive low address/data on low port, high address on high port.
// RULE17: External party answers within the strobe width given by the stretch.
`timescale 1ns/1ps
module data_memory_access_unit #(
  parameter int SRAM_WORDS = dmem_pkg::SRAM_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dmem_pkg::move_req_t move_req,
  input wire dmem_pkg::ptr_cmd_t ptr_cmd,
  output logic move_busy,
  output logic move_done,
  output logic [7:0] move_rdata,
  output logic [15:0] active_pointer,
  input wire logic [2:0] security_lock_flags,
  input wire logic [7:0] low_bus_port_i,
  output dmem_pkg::ext_pins_t ext_pins
);

  typedef enum logic [1:0] {IDLE, INT_ACC, EXT_ACC, NO_ACC} acc_state_t;

  // Strobe width in clocks for a stretch value.
  function automatic logic [5:0] strobe_clks(input logic [2:0] s);
    if (s == 3'h0) begin
      strobe_clks = dmem_pkg::STROBE_CLKS_ZERO; // RULE10
    end else begin
      strobe_clks = {1'b0, s, 2'b00}; // RULE10
    end
  endfunction : strobe_clks

  // Setup (and hold) extension of one clock for any nonzero stretch.
  function automatic logic [5:0] extra_clk(input logic [2:0] s);
    extra_clk = (s != 3'h0) ? 6'h01 : 6'h00; // RULE11
  endfunction : extra_clk

  // Registers.
  logic [15:0] ptr0_ff;
  logic [15:0] ptr1_ff;
  logic ptr_sel_ff;
  logic [7:0] clk_ctl_ff;
  logic [7:0] pwr_mgt_ff;
  logic [7:0] sram [SRAM_WORDS];
  acc_state_t state_ff;
  logic [5:0] cnt_ff;
  logic [5:0] last_ff;
  logic [5:0] strobe_beg_ff;
  logic [5:0] strobe_end_ff;
  logic write_ff;
  logic [15:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] rdata_ff;
  logic done_ff;
  dmem_pkg::ext_pins_t pins_ff;
  logic [7:0] p0_meta_ff;
  logic [7:0] p0_sync_ff;
  logic [2:0] lock_meta_ff;
  logic [2:0] lock_sync_ff;

  // APB decode; the slave always answers in the access cycle.
  wire apb_access = psel && penable;
  wire [7:0] reg_idx = paddr[9:2];
  wire upper_zero = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  wire hit_p0l = upper_zero && (reg_idx == dmem_pkg::IDX_PTR0_LO);
  wire hit_p0h = upper_zero && (reg_idx == dmem_pkg::IDX_PTR0_HI);
  wire hit_p1l = upper_zero && (reg_idx == dmem_pkg::IDX_PTR1_LO);
  wire hit_p1h = upper_zero && (reg_idx == dmem_pkg::IDX_PTR1_HI);
  wire hit_sel = upper_zero && (reg_idx == dmem_pkg::IDX_PTR_SEL);
  wire hit_ckc = upper_zero && (reg_idx == dmem_pkg::IDX_CLK_CTL);
  wire hit_pmr = upper_zero && (reg_idx == dmem_pkg::IDX_PWR_MGT);
  wire hit_any = hit_p0l || hit_p0h || hit_p1l || hit_p1h || hit_sel || hit_ckc || hit_pmr;
  wire apb_wr = apb_access && pwrite && hit_any;
  wire [7:0] wbyte = pwdata[7:0];

  assign pready = 1'b1;
  assign pslverr = apb_access && !hit_any;

  // Read mux; bits above the byte and reserved select bits read zero.
  wire [7:0] rd_byte =
    hit_p0l ? ptr0_ff[7:0] :
    hit_p0h ? ptr0_ff[15:8] :
    hit_p1l ? ptr1_ff[7:0] :
    hit_p1h ? ptr1_ff[15:8] :
    hit_sel ? {7'h00, ptr_sel_ff} : // RULE14
    hit_ckc ? clk_ctl_ff :
    hit_pmr ? pwr_mgt_ff : 8'h00;
  assign prdata = {24'h000000, rd_byte};

  // Selected pointer and its next values.
  assign active_pointer = ptr_sel_ff ? ptr1_ff : ptr0_ff; // RULE15
  wire [15:0] ptr_next = ptr_cmd.load ? ptr_cmd.value : active_pointer + 16'h0001;
  wire ptr_touch = ptr_cmd.load || ptr_cmd.inc;
  wire [15:0] nxt_ptr0 = (ptr_touch && !ptr_sel_ff) ? ptr_next : ptr0_ff;
  wire [15:0] nxt_ptr1 = (ptr_touch && ptr_sel_ff) ? ptr_next : ptr1_ff;

  // Pointer registers: a core command wins over a same-cycle bus write to that byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr0_ff <= {dmem_pkg::RST_PTR, dmem_pkg::RST_PTR};
      ptr1_ff <= {dmem_pkg::RST_PTR, dmem_pkg::RST_PTR};
    end else begin
      ptr0_ff[7:0] <= (apb_wr && hit_p0l && !(ptr_touch && !ptr_sel_ff)) ? wbyte : nxt_ptr0[7:0]; // RULE13
      ptr0_ff[15:8] <= (apb_wr && hit_p0h && !(ptr_touch && !ptr_sel_ff)) ? wbyte : nxt_ptr0[15:8]; // RULE13
      ptr1_ff[7:0] <= (apb_wr && hit_p1l && !(ptr_touch && ptr_sel_ff)) ? wbyte : nxt_ptr1[7:0]; // RULE13
      ptr1_ff[15:8] <= (apb_wr && hit_p1h && !(ptr_touch && ptr_sel_ff)) ? wbyte : nxt_ptr1[15:8]; // RULE13
    end
  end

  // Control registers; mapping and stretch may change at any time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_sel_ff <= dmem_pkg::RST_PTR_SEL[0];
      clk_ctl_ff <= dmem_pkg::RST_CLK_CTL; // RULE9
      pwr_mgt_ff <= dmem_pkg::RST_PWR_MGT; // RULE2
    end else if (apb_wr) begin
      if (hit_sel) begin
        ptr_sel_ff <= wbyte[0]; // RULE14
      end
      if (hit_ckc) begin
        clk_ctl_ff <= wbyte; // RULE8
      end
      if (hit_pmr) begin
        pwr_mgt_ff <= wbyte; // RULE1
      end
    end
  end

  // Two-flop synchronisers for the port read data and the lock straps.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p0_meta_ff <= 8'h00;
      p0_sync_ff <= 8'h00;
      lock_meta_ff <= 3'h0;
      lock_sync_ff <= 3'h0;
    end else begin
      p0_meta_ff <= low_bus_port_i;
      p0_sync_ff <= p0_meta_ff;
      lock_meta_ff <= security_lock_flags;
      lock_sync_ff <= lock_meta_ff;
    end
  end

  // Address decode of a new request against the current mapping code.
  wire [1:0] map_code = {pwr_mgt_ff[dmem_pkg::MAP_CTL_HI_BIT],
                         pwr_mgt_ff[dmem_pkg::MAP_CTL_LO_BIT]};
  wire [15:0] req_addr = move_req.use_ptr ? active_pointer : move_req.addr; // RULE15
  wire low_kb = (req_addr <= dmem_pkg::SRAM_LAST_ADDR);
  wire is_lock = (req_addr == dmem_pkg::LOCK_STATUS_ADDR);
  // Reserved code 10 is treated like 00 so a stray setting cannot hide external parts.
  wire go_int = ((map_code == dmem_pkg::MAP_LOW_INT) || (map_code == dmem_pkg::MAP_LOCK_VIEW))
                && low_kb; // RULE3 RULE4
  wire go_none = (map_code == dmem_pkg::MAP_LOCK_VIEW) && !low_kb; // RULE4
  wire go_ext = !go_int && !go_none; // RULE2 RULE3
  wire start = move_req.valid && (state_ff == IDLE);

  // Timing plan of an external move taken from the stretch at request time.
  wire [2:0] stretch = clk_ctl_ff[dmem_pkg::STRETCH_MSB:dmem_pkg::STRETCH_LSB];
  wire [5:0] plan_sbeg = dmem_pkg::ALE_CLKS + dmem_pkg::SETUP_CLKS + extra_clk(stretch); // RULE11
  wire [5:0] plan_send = plan_sbeg + strobe_clks(stretch); // RULE10
  wire [5:0] plan_ext_last = 6'((6'({3'h0, stretch}) + 6'h02) * dmem_pkg::CLKS_PER_MCYC)
                             - 6'h01; // RULE8
  wire [5:0] plan_int_last = 6'(dmem_pkg::INT_MCYC * dmem_pkg::CLKS_PER_MCYC) - 6'h01; // RULE7
  wire at_last = (cnt_ff == last_ff);

  // Access sequencer: one counter walks every kind of move to its fixed length.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= IDLE;
      cnt_ff <= 6'h00;
      last_ff <= 6'h00;
      strobe_beg_ff <= 6'h00;
      strobe_end_ff <= 6'h00;
      write_ff <= 1'b0;
      addr_ff <= 16'h0000;
      wdata_ff <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      unique case (state_ff)
        IDLE: begin
          cnt_ff <= 6'h00;
          if (start) begin
            write_ff <= move_req.write;
            addr_ff <= req_addr;
            wdata_ff <= move_req.wdata;
            strobe_beg_ff <= plan_sbeg;
            strobe_end_ff <= plan_send;
            last_ff <= go_ext ? plan_ext_last : plan_int_last; // RULE7 RULE8
            state_ff <= go_ext ? EXT_ACC : (go_int ? INT_ACC : NO_ACC);
          end
        end
        INT_ACC, EXT_ACC, NO_ACC: begin
          cnt_ff <= cnt_ff + 6'h01;
          if (at_last) begin
            done_ff <= 1'b1;
            state_ff <= IDLE;
          end
        end
      endcase
    end
  end

  // On-chip SRAM; only data moves write it, so mapping changes leave it intact.
  wire sram_we = (state_ff == INT_ACC) && write_ff && (cnt_ff == 6'h00); // RULE6
  always_ff @(posedge pclk) begin
    if (sram_we) begin
      sram[addr_ff[9:0]] <= wdata_ff;
    end
  end

  // Read data capture for each kind of move.
  wire int_rd = (state_ff == INT_ACC) && !write_ff && (cnt_ff == 6'h00);
  wire none_rd = (state_ff == NO_ACC) && !write_ff && (cnt_ff == 6'h00);
  wire ext_rd = (state_ff == EXT_ACC) && !write_ff
                && (cnt_ff == strobe_end_ff + dmem_pkg::SYNC_LAG_CLKS); // RULE17
  wire [7:0] lock_byte = {5'h00, lock_sync_ff}; // RULE5
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 8'h00;
    end else if (int_rd) begin
      rdata_ff <= sram[addr_ff[9:0]];
    end else if (none_rd) begin
      rdata_ff <= (addr_ff == dmem_pkg::LOCK_STATUS_ADDR) ? lock_byte : 8'h00; // RULE4 RULE5
    end else if (ext_rd) begin
      rdata_ff <= p0_sync_ff;
    end
  end

  // Pin plan: address phase with ALE, setup, strobe, then hold; only data moves
  // use it, and the fetch path never sees the stretch.
  wire ext_on = (state_ff == EXT_ACC); // RULE12
  wire in_ale = ext_on && (cnt_ff < dmem_pkg::ALE_CLKS);
  wire in_strobe = ext_on && (cnt_ff >= strobe_beg_ff) && (cnt_ff < strobe_end_ff); // RULE10
  wire drive_data = ext_on && write_ff && !in_ale;
  dmem_pkg::ext_pins_t nxt_pins;
  always_comb begin
    nxt_pins.ale = in_ale;
    nxt_pins.rd_n = !(in_strobe && !write_ff);
    nxt_pins.wr_n = !(in_strobe && write_ff);
    nxt_pins.low_bus_port_o = in_ale ? addr_ff[7:0] : (drive_data ? wdata_ff : 8'h00); // RULE16
    nxt_pins.low_bus_port_oe = in_ale || drive_data; // RULE16
    nxt_pins.high_address_port = ext_on ? addr_ff[15:8] : 8'h00; // RULE16
    nxt_pins.bus_active = ext_on;
  end

  // Registered pins keep glitches off the strobes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_ff <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, low_bus_port_o: 8'h00,
                   low_bus_port_oe: 1'b0, high_address_port: 8'h00, bus_active: 1'b0};
    end else begin
      pins_ff <= nxt_pins;
    end
  end

  assign ext_pins = pins_ff;
  assign move_busy = (state_ff != IDLE);
  assign move_done = done_ff;
  assign move_rdata = rdata_ff;

endmodule : data_memory_access_unit

// >>> hdl/dmem_pkg.sv
// Purpose: Shared constants and carrier types for the data-memory access unit.
// Assumes: APB register bus with 32-bit data, one register per aligned word.
// Notes: Register offsets are indices; the byte address is four times the index.
package dmem_pkg;

  // Register indices as printed; byte address = index * 4.
  localparam logic [7:0] IDX_PTR0_LO = 8'h82;
  localparam logic [7:0] IDX_PTR0_HI = 8'h83;
  localparam logic [7:0] IDX_PTR1_LO = 8'h84;
  localparam logic [7:0] IDX_PTR1_HI = 8'h85;
  localparam logic [7:0] IDX_PTR_SEL = 8'h86;
  localparam logic [7:0] IDX_CLK_CTL = 8'h8e;
  localparam logic [7:0] IDX_PWR_MGT = 8'hc4;

  // Values after reset.
  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [7:0] RST_PTR_SEL = 8'h00;
  localparam logic [7:0] RST_CLK_CTL = 8'h01;
  localparam logic [7:0] RST_PWR_MGT = 8'h40;

  // Field positions.
  localparam int MAP_CTL_LO_BIT = 0;
  localparam int MAP_CTL_HI_BIT = 1;
  localparam int STRETCH_LSB = 0;
  localparam int STRETCH_MSB = 2;

  // Address map of the data space.
  localparam logic [15:0] SRAM_LAST_ADDR = 16'h03ff;
  localparam logic [15:0] LOCK_STATUS_ADDR = 16'hfffc;
  localparam int SRAM_DEPTH = 1024;

  // Cycle counts in clocks, except INT_MCYC, which counts machine cycles.
  localparam logic [5:0] CLKS_PER_MCYC = 6'h04;
  localparam logic [5:0] INT_MCYC = 6'h02;
  localparam logic [5:0] ALE_CLKS = 6'h02;
  localparam logic [5:0] SETUP_CLKS = 6'h01;
  localparam logic [5:0] STROBE_CLKS_ZERO = 6'h02;
  localparam logic [5:0] SYNC_LAG_CLKS = 6'h02;

  // Mapping codes.
  localparam logic [1:0] MAP_ALL_EXT = 2'h0;
  localparam logic [1:0] MAP_LOW_INT = 2'h1;
  localparam logic [1:0] MAP_RESERVED = 2'h2;
  localparam logic [1:0] MAP_LOCK_VIEW = 2'h3;

  // A data-move request from the core.
  typedef struct packed {
    logic valid;
    logic write;
    logic use_ptr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } move_req_t;

  // A pointer command from the core: load or increment the selected pointer.
  typedef struct packed {
    logic load;
    logic inc;
    logic [15:0] value;
  } ptr_cmd_t;

  // Pins of the external multiplexed bus.
  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
    logic [7:0] low_bus_port_o;
    logic low_bus_port_oe;
    logic [7:0] high_address_port;
    logic bus_active;
  } ext_pins_t;

endpackage : dmem_pkg

// >>> verification/data_memory_access_unit_asserts.sv
// Purpose: Port-level assertions for the data-memory access unit.
// Assumes: Mapping and stretch are mirrored from the APB writes seen at the ports.
// Notes: Move length is judged by a counter that restarts at each take edge.
`timescale 1ns/1ps
module dmem_unit_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire dmem_pkg::move_req_t move_req,
  input wire logic move_busy,
  input wire logic move_done,
  input wire logic [15:0] active_pointer,
  input wire dmem_pkg::ext_pins_t ext_pins
);
  logic [1:0] map_ff;
  logic [2:0] s_ff, ms_ff;
  logic ext_ff;
  logic [7:0] cnt_ff, exp_ff, low_ff;
  // Decode of the request as the unit must see it; a take may use the live pointer.
  wire acc = psel & penable;
  wire take = move_req.valid & ~move_busy;
  wire [15:0] ma = move_req.use_ptr ? active_pointer : move_req.addr;
  wire is_ext = ~map_ff[0] | (~map_ff[1] & (ma > dmem_pkg::SRAM_LAST_ADDR));
  wire strb = ~ext_pins.rd_n | ~ext_pins.wr_n;
  wire [3:0] mcyc = {1'b0, s_ff} + 4'h2;
  wire [7:0] wid = (ms_ff == 3'h0) ? 8'h02 : {3'h0, ms_ff, 2'h0};
  wire mapped = paddr inside {12'h208, 12'h20c, 12'h210, 12'h214, 12'h218, 12'h238, 12'h310};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Stretch is latched at the take, so a later write cannot bend a move in flight.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_ff <= dmem_pkg::RST_PWR_MGT[1:0];
      s_ff <= dmem_pkg::RST_CLK_CTL[2:0];
      ms_ff <= 3'h0;
      ext_ff <= 1'b0;
      cnt_ff <= 8'h00;
      exp_ff <= 8'h00;
      low_ff <= 8'h00;
    end else begin
      if (acc && pwrite && paddr == 12'h310) map_ff <= pwdata[1:0];
      if (acc && pwrite && paddr == 12'h238) s_ff <= pwdata[2:0];
      cnt_ff <= take ? 8'h00 : cnt_ff + 8'h01;
      low_ff <= strb ? low_ff + 8'h01 : 8'h00;
      if (take) begin
        ms_ff <= s_ff;
        ext_ff <= is_ext;
        exp_ff <= is_ext ? {2'h0, mcyc, 2'h0} : 8'h08;
      end
    end
  end
  chk_sel_reads_zero: assert property (acc && !pwrite && paddr == 12'h218 |-> prdata[31:1] == 31'h0)
    else $error("pointer select shows upper bits set");
  chk_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_done_time: assert property (move_done |-> cnt_ff == exp_ff)
    else $error("move finished after the wrong count");
  chk_busy_bound: assert property (move_busy |-> cnt_ff < exp_ff)
    else $error("move still busy past its length");
  chk_done_pulse: assert property (move_done |=> !move_done)
    else $error("done wider than one clock");
  chk_strobe_width: assert property ($fell(strb) |-> low_ff == wid)
    else $error("strobe width wrong for stretch");
  // One setup clock follows the address phase, and a second one for any nonzero stretch.
  chk_setup_clock: assert property ($fell(ext_pins.ale) |-> if (ms_ff == 3'h0) (!strb ##1 strb)
    else (!strb ##1 !strb ##1 strb))
    else $error("strobe setup gap wrong");
  chk_int_quiet: assert property (move_busy && !ext_ff |-> !ext_pins.ale && !strb)
    else $error("bus cycle on an internal move");
  chk_ale_drive: assert property (ext_pins.ale |-> ext_pins.low_bus_port_oe && ext_pins.bus_active)
    else $error("address phase without driving the bus");
  chk_read_release: assert property (!ext_pins.rd_n |-> !ext_pins.low_bus_port_oe)
    else $error("unit drives the bus during a read strobe");
  cov_ext_take: cover property (take && is_ext);
  cov_int_take: cover property (take && !is_ext);
  cov_long_strobe: cover property ($fell(strb) && ms_ff == 3'h7);
endmodule : dmem_unit_asserts

bind data_memory_access_unit dmem_unit_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pslverr, .move_req, .move_busy, .move_done, .active_pointer,
  .ext_pins);

// >>> verification/ext_ram_model.sv
// Purpose: External byte memory on the multiplexed bus, far side of the unit.
// Assumes: Address latched while ale is high; writes captured while the write strobe is low.
// Notes: Read data appears lat clocks into the strobe and holds one clock past it.
`timescale 1ns/1ps
module ext_ram_model (
  input wire logic pclk,
  input wire dmem_pkg::ext_pins_t ext_pins,
  input wire logic [4:0] lat,
  output logic [7:0] low_bus_port_i
);
  logic [7:0] mem [0:65535];
  logic [15:0] a_ff;
  logic [4:0] n_ff;
  logic hold_ff;
  logic [7:0] last_ff = 8'h00;
  // Data is valid only late in the strobe when slow, and for one hold clock after it.
  wire ok = ~ext_pins.rd_n ? (n_ff >= lat) : hold_ff;
  // A released bus shows the inverse of the last byte, so stale data never passes.
  assign low_bus_port_i = ok ? mem[a_ff] : ~last_ff;
  // Latch, capture and strobe counting all follow the pins only.
  always_ff @(posedge pclk) begin
    if (ext_pins.ale) a_ff <= {ext_pins.high_address_port, ext_pins.low_bus_port_o};
    if (!ext_pins.wr_n) mem[a_ff] <= ext_pins.low_bus_port_o;
    hold_ff <= ~ext_pins.rd_n;
    n_ff <= ~ext_pins.rd_n ? n_ff + 5'h01 : 5'h00;
    if (ok) last_ff <= low_bus_port_i;
  end
endmodule : ext_ram_model

// >>> verification/data_memory_access_unit_tb.sv
// Purpose: Self-checking bench for the data-memory access unit.
// Assumes: Memory model on the far side; lock straps start at 5 and later change to 2.
// Notes: Move lengths are counted in clocks from the take edge to the done pulse.
`timescale 1ns/1ps
module data_memory_access_unit_tb;
  localparam logic [7:0] PW = dmem_pkg::IDX_PWR_MGT;
  localparam logic [7:0] CK = dmem_pkg::IDX_CLK_CTL;
  localparam logic [7:0] SL = dmem_pkg::IDX_PTR_SEL;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, move_busy, move_done, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] move_rdata, low_bus_port_i;
  logic [15:0] active_pointer;
  logic [2:0] security_lock_flags;
  logic [4:0] lat;
  dmem_pkg::move_req_t move_req;
  dmem_pkg::ptr_cmd_t ptr_cmd;
  dmem_pkg::ext_pins_t ext_pins;
  int n_mismatch = 0;
  int checked = 0;
  // The unit and the memory answering on its external bus.
  data_memory_access_unit u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .move_req, .ptr_cmd, .move_busy, .move_done, .move_rdata,
    .active_pointer, .security_lock_flags, .low_bus_port_i, .ext_pins);
  ext_ram_model u_ram (.pclk, .ext_pins, .lat, .low_bus_port_i);
  // Clock at 50 MHz.
  always #10 pclk = ~pclk;
  task test_done();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // A wait that runs out ends the run, since nothing after it could be trusted.
  task guard(input int k);
    if (k >= 100) begin
      n_mismatch++;
      test_done();
    end
  endtask : guard
  // One APB transfer; the request stands until pready is seen high at an edge.
  task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    guard(k);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task rd(input logic [7:0] i, input logic [31:0] x, input logic xe);
    apb(1'b0, i, 8'h00);
    cmp(r, x);
    cmp({31'h0, e}, {31'h0, xe});
  endtask : rd
  // One data move; ec is its length in clocks. The done pulse is registered, so it is
  // first seen one edge after the last busy clock.
  task mv(input logic w, input logic up, input logic [15:0] a, input logic [7:0] d,
    input logic [7:0] x, input int ec);
    int n;
    move_req <= '{1'b1, w, up, a, d};
    @(posedge pclk);
    move_req.valid <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (move_done !== 1'b1 && n < 100);
    guard(n);
    cmp(n, ec + 1);
    if (!w) cmp({24'h0, move_rdata}, {24'h0, x});
  endtask : mv
  // Reset values, then both pointers through registers and pointer 1 through core commands.
  task t_regs();
    rd(CK, 32'h01, 1'b0);
    rd(PW, {24'h0, dmem_pkg::RST_PWR_MGT}, 1'b0);
    rd(8'h87, 32'h0, 1'b1);
    for (int i = 0; i < 4; i++) apb(1'b1, 8'(dmem_pkg::IDX_PTR0_LO + i), 8'(8'h31 + 8'h11 * i));
    for (int i = 0; i < 4; i++) rd(8'(dmem_pkg::IDX_PTR0_LO + i), 32'(8'h31 + 8'h11 * i), 1'b0);
    cmp({16'h0, active_pointer}, 32'h4231);
    apb(1'b1, SL, 8'hff);
    rd(SL, 32'h01, 1'b0);
    cmp({16'h0, active_pointer}, 32'h6453);
    ptr_cmd <= '{1'b1, 1'b1, 16'h03fe};
    @(posedge pclk);
    ptr_cmd <= '{1'b0, 1'b1, 16'h0000};
    @(posedge pclk);
    ptr_cmd <= '0;
    @(posedge pclk);
    rd(SL + 8'h00 - 8'h02, 32'hff, 1'b0);
    rd(dmem_pkg::IDX_PTR0_LO, 32'h31, 1'b0);
  endtask : t_regs
  // Routing under mapping codes 00 and 01, back to back, SRAM kept across changes.
  task t_route();
    mv(1'b1, 1'b1, 16'h0, 8'ha5, 8'h0, 12);
    cmp({24'h0, u_ram.mem[16'h03ff]}, 32'ha5);
    apb(1'b1, PW, 8'h41);
    mv(1'b1, 1'b0, 16'h03ff, 8'h5a, 8'h0, 8);
    mv(1'b0, 1'b1, 16'h0, 8'h0, 8'h5a, 8);
    mv(1'b1, 1'b0, 16'h0400, 8'h3c, 8'h0, 12);
    cmp({16'h0, u_ram.mem[16'h03ff], u_ram.mem[16'h0400]}, 32'ha53c);
    apb(1'b1, PW, 8'h40);
    mv(1'b0, 1'b0, 16'h03ff, 8'h0, 8'ha5, 12);
    apb(1'b1, PW, 8'h41);
    mv(1'b0, 1'b0, 16'h03ff, 8'h0, 8'h5a, 8);
  endtask : t_route
  // Every stretch value, with the far side answering as late as it may.
  task t_stretch();
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, CK, 8'(s));
      lat <= (s == 0) ? 5'h01 : 5'(4 * s - 1);
      mv(1'b1, 1'b0, 16'(16'h1200 + s), 8'(8'hc0 + s), 8'h0, 4 * (s + 2));
      mv(1'b0, 1'b0, 16'(16'h1200 + s), 8'h0, 8'(8'hc0 + s), 4 * (s + 2));
      mv(1'b0, 1'b0, 16'h03ff, 8'h0, 8'h5a, 8);
    end
  endtask : t_stretch
  // Lock view, reserved places and the reserved mapping code.
  task t_lock();
    apb(1'b1, PW, 8'h43);
    mv(1'b0, 1'b0, 16'hfffc, 8'h0, 8'h05, 8);
    mv(1'b1, 1'b0, 16'h0400, 8'hee, 8'h0, 8);
    mv(1'b0, 1'b0, 16'hfffd, 8'h0, 8'h00, 8);
    cmp({24'h0, u_ram.mem[16'h0400]}, 32'h3c);
    security_lock_flags <= 3'h2;
    repeat (4) @(posedge pclk);
    mv(1'b0, 1'b0, 16'hfffc, 8'h0, 8'h02, 8);
    apb(1'b1, PW, 8'h42);
    mv(1'b1, 1'b0, 16'h0010, 8'h77, 8'h0, 36);
    cmp({24'h0, u_ram.mem[16'h0010]}, 32'h77);
  endtask : t_lock
  // Reset for ten clocks, then each scenario in turn.
  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    move_req <= '0;
    ptr_cmd <= '0;
    security_lock_flags <= 3'h5;
    lat <= 5'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_route();
    t_stretch();
    t_lock();
    test_done();
  end
endmodule : data_memory_access_unit_tb
